// ---- verilog/tmfd_pkg.sv ----
// constants and types for the fetch instruction decoder
package tmfd_pkg;
    // register byte offsets
    localparam logic [7:0] TMFD_TEX_W0_OFS  = 8'h00;
    localparam logic [7:0] TMFD_TEX_W1_OFS  = 8'h04;
    localparam logic [7:0] TMFD_TEX_W2_OFS  = 8'h08;
    localparam logic [7:0] TMFD_TEX_W3_OFS  = 8'h0c;
    localparam logic [7:0] TMFD_MEM_W0_OFS  = 8'h10;
    localparam logic [7:0] TMFD_CTRL_OFS    = 8'h14;
    localparam logic [7:0] TMFD_INDEX_OFS   = 8'h18;
    localparam logic [7:0] TMFD_IDXVAL_OFS  = 8'h1c;
    localparam logic [7:0] TMFD_STATUS_OFS  = 8'h20;
    localparam logic [7:0] TMFD_TEXDEC_OFS  = 8'h24;
    localparam logic [7:0] TMFD_MEMDEC_OFS  = 8'h28;
    // texture word 0 fields
    localparam int TMFD_OP_LSB     = 0;
    localparam int TMFD_MOD_LSB    = 5;
    localparam int TMFD_FWQ_BIT    = 7;
    localparam int TMFD_RES_LSB    = 8;
    localparam int TMFD_SRC_LSB    = 16;
    localparam int TMFD_SREL_BIT   = 23;
    localparam int TMFD_ALT_BIT    = 24;
    localparam int TMFD_RIM_LSB    = 25;
    localparam int TMFD_SIM_LSB    = 27;
    // texture word 1 fields
    localparam int TMFD_DST_LSB    = 0;
    localparam int TMFD_DREL_BIT   = 7;
    localparam int TMFD_DSEL_LSB   = 9;
    localparam int TMFD_LOD_LSB    = 21;
    localparam int TMFD_CT_LSB     = 28;
    // texture word 2 fields
    localparam int TMFD_OFS_LSB    = 0;
    localparam int TMFD_SAMP_LSB   = 15;
    localparam int TMFD_SSEL_LSB   = 20;
    // memory-read word 0 fields
    localparam int TMFD_ESZ_LSB    = 5;
    localparam int TMFD_MOP_LSB    = 8;
    localparam int TMFD_UNC_BIT    = 11;
    localparam int TMFD_IDX_BIT    = 12;
    localparam int TMFD_MCOMP_LSB  = 24;
    localparam int TMFD_BURST_LSB  = 26;
    // index register and readback fields
    localparam int TMFD_I0_LSB     = 8;
    localparam int TMFD_I1_LSB     = 16;
    localparam int TMFD_STEP_LSB   = 4;
    localparam int TMFD_BUSY_BIT   = 2;
    localparam int TMFD_MERR_BIT   = 1;
    localparam int TMFD_TERR_BIT   = 0;
    localparam int TMFD_DSAMP_LSB  = 8;
    localparam int TMFD_DSRC_LSB   = 16;
    localparam int TMFD_DDST_LSB   = 24;
    localparam int TMFD_DELEM_LSB  = 20;
    localparam int TMFD_DBURST_LSB = 24;
    // opcodes
    localparam logic [4:0] TMFD_OP_LD        = 5'h03;
    localparam logic [4:0] TMFD_OP_GRAD_H    = 5'h07;
    localparam logic [4:0] TMFD_OP_GRAD_V    = 5'h08;
    localparam logic [4:0] TMFD_OP_RSV_HI    = 5'h0d;
    localparam logic [4:0] TMFD_OP_SAMPLE    = 5'h10;
    localparam logic [4:0] TMFD_OP_SAMPLE_G  = 5'h14;
    localparam logic [4:0] TMFD_OP_GATHER4   = 5'h15;
    localparam logic [4:0] TMFD_OP_SMP_G_LB  = 5'h16;
    localparam logic [4:0] TMFD_OP_GATHER4_O = 5'h17;
    localparam logic [4:0] TMFD_OP_SAMPLE_C  = 5'h18;
    localparam logic [4:0] TMFD_OP_SMP_C_G   = 5'h1c;
    localparam logic [4:0] TMFD_OP_GATHER4_C = 5'h1d;
    localparam logic [4:0] TMFD_OP_SC_G_LB   = 5'h1e;
    localparam logic [4:0] TMFD_OP_G4_C_O    = 5'h1f;
    localparam logic [4:0] TMFD_MEM_OPCODE   = 5'h02;
    localparam logic [4:0] TMFD_SAMP_MAX     = 5'h11;
    // modifier, index mode, selector and sub-opcode codes
    localparam logic [1:0] TMFD_MOD_FMASK    = 2'h1;
    localparam logic [1:0] TMFD_MOD_FINE     = 2'h1;
    localparam logic [1:0] TMFD_IDX_NONE     = 2'h0;
    localparam logic [1:0] TMFD_IDX_0        = 2'h1;
    localparam logic [1:0] TMFD_IDX_1        = 2'h2;
    localparam logic [1:0] TMFD_IDX_BAD      = 2'h3;
    localparam logic [2:0] TMFD_SEL_RSVD     = 3'h6;
    localparam logic [2:0] TMFD_SEL_ONE      = 3'h5;
    localparam logic [1:0] TMFD_ESZ_ONE      = 2'h0;
    localparam logic [1:0] TMFD_ESZ_TWO      = 2'h1;
    localparam logic [1:0] TMFD_ESZ_BAD      = 2'h2;
    localparam logic [2:0] TMFD_MOP_SCRATCH  = 3'h0;
    localparam logic [2:0] TMFD_MOP_SCATTER  = 3'h2;

    typedef enum logic [2:0] {
        TMFD_PROG_PIXEL   = 3'h0,
        TMFD_PROG_VERTEX  = 3'h1,
        TMFD_PROG_GEOM    = 3'h2,
        TMFD_PROG_EXPORT  = 3'h3,
        TMFD_PROG_HULL    = 3'h4,
        TMFD_PROG_LOCAL   = 3'h5,
        TMFD_PROG_COMPUTE = 3'h6
    } tmfd_prog_type;

    typedef enum logic {
        TMFD_IDLE = 1'b0,
        TMFD_RUN  = 1'b1
    } tmfd_burst_type;
endpackage : tmfd_pkg

// ---- verilog/tmfd_decoder.sv ----
// texture and memory-read fetch instruction decoder with ahb-lite registers
// Functional notes
// - opcodes 20-31 are gradient, gather, compare variants
// - load modifier selects normal or fragment-pointer load
// - gradient modifier selects coarse or fine derivatives
// - gather4 (opcode 21) modifier picks gathered element, other gathers get 0
// - bit 7 forces whole-quad fetch
// - eight-bit surface resource select
// - source register, optionally plus loop index
// - alternate constants, ignored for hull/local/compute
// - resource index mode adds index0 or index1
// - sampler index mode, same encoding
// - destination register, relative bit, four selectors
// - signed S3.3 level-of-detail bias
// - per-component coordinate normalization bits
// - three S3.1 texel offsets x, y, z
// - sampler select must stay within 0-17
// - four source component selectors
// - memory opcode must be 2
// - element size scales index value
// - sub-opcode scratch or scatter read only
// - indexed access uses chosen source component
// - burst of 1-16 reads, stepping base and dest
// - three words plus ignored zero padding word
`timescale 1ns/1ns
module tmfd_decoder
    import tmfd_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // texture fetch unit
    output logic             tex_valid,
    output logic [4:0]       texture_opcode,
    output logic             tex_variant,
    output logic             tex_gradient_variant,
    output logic             gather_four_op,
    output logic             tex_compare_variant,
    output logic             direct_load_fmask,
    output logic             gradient_fine,
    output logic [1:0]       gather_element,
    output logic             full_quad_fetch,
    output logic [7:0]       surface_select,
    output logic [4:0]       filter_state_select,
    output logic [6:0]       source_reg_index,
    output logic             alternate_thread_constants,
    output logic [6:0]       dest_reg_index,
    output logic [11:0]      dest_select,
    output logic [6:0]       lod_bias,
    output logic [3:0]       coordinate_normalization,
    output logic [14:0]      texel_offsets,
    output logic [11:0]      source_select,
    output logic             tex_error,
    // memory fetch unit
    output logic             mem_read_valid,
    output logic [3:0]       mem_burst_step,
    output logic [2:0]       memory_sub_opcode,
    output logic             mem_uncached,
    output logic [6:0]       mem_source_reg_index,
    output logic [1:0]       mem_source_component,
    output logic [17:0]      mem_index_scaled,
    output logic             mem_error
);

    typedef struct packed {
        logic           wr_pend;
        logic           rd_pend;
        logic [7:0]     addr;
        logic [31:0]    rdata;
        logic [31:0]    tw0;
        logic [31:0]    tw1;
        logic [31:0]    tw2;
        logic [31:0]    mw0;
        tmfd_prog_type  prog;
        logic [7:0]     loop_idx;
        logic [7:0]     idx0;
        logic [7:0]     idx1;
        logic [15:0]    idx_val;
        logic           tex_go;
        logic           mem_go;
        logic           tex_valid;
        logic [4:0]     op;
        logic           variant;
        logic           grad_var;
        logic           gather;
        logic           cmp;
        logic           fmask;
        logic           fine;
        logic [1:0]     gather_el;
        logic           full_quad;
        logic [7:0]     res;
        logic [4:0]     samp;
        logic [6:0]     src;
        logic           alt;
        logic [6:0]     dst;
        logic [11:0]    dsel;
        logic [6:0]     lod;
        logic [3:0]     cnorm;
        logic [14:0]    offs;
        logic [11:0]    ssel;
        logic           tex_err;
        tmfd_burst_type bst;
        logic [3:0]     step;
        logic [3:0]     last;
        logic           mvalid;
        logic [2:0]     mop;
        logic           unc;
        logic [6:0]     msrc;
        logic [1:0]     mcomp;
        logic [17:0]    mscaled;
        logic [1:0]     esz;
        logic           mem_err;
    } tmfd_state_type;

    tmfd_state_type s_ff;
    tmfd_state_type nxt_s;

    logic        take;
    logic [4:0]  op;
    logic [1:0]  md;
    logic [7:0]  radd;
    logic [4:0]  sadd;
    logic        terr;
    logic        merr;
    logic [1:0]  esz;
    logic [2:0]  mop;
    logic [17:0] scaled;
    logic [31:0] rd;

    always_comb begin
        nxt_s     = s_ff;
        take      = hsel & htrans[1] & hready;
        op        = s_ff.tw0[TMFD_OP_LSB +: 5];
        md        = s_ff.tw0[TMFD_MOD_LSB +: 2];
        terr      = 1'b0;
        esz       = s_ff.mw0[TMFD_ESZ_LSB +: 2];
        mop       = s_ff.mw0[TMFD_MOP_LSB +: 3];
        merr      = 1'b0;
        scaled    = 18'h00000;
        rd        = 32'h00000000;

        // register writes in the data phase
        nxt_s.tex_go = 1'b0;
        nxt_s.wr_pend = 1'b0;
        nxt_s.rd_pend = 1'b0;
        if (s_ff.wr_pend) begin
            case (s_ff.addr)
                TMFD_TEX_W0_OFS: nxt_s.tw0 = hwdata;
                TMFD_TEX_W1_OFS: nxt_s.tw1 = hwdata;
                TMFD_TEX_W2_OFS: begin
                    nxt_s.tw2    = hwdata;
                    nxt_s.tex_go = 1'b1;
                end
                TMFD_MEM_W0_OFS: nxt_s.mw0 = hwdata;
                TMFD_CTRL_OFS: nxt_s.prog = tmfd_prog_type'(hwdata[2:0]);
                TMFD_INDEX_OFS: begin
                    nxt_s.loop_idx = hwdata[7:0];
                    nxt_s.idx0     = hwdata[TMFD_I0_LSB +: 8];
                    nxt_s.idx1     = hwdata[TMFD_I1_LSB +: 8];
                end
                TMFD_IDXVAL_OFS: nxt_s.idx_val = hwdata[15:0];
                default: ; // padding word and unmapped writes are dropped
            endcase
        end

        // read mux, one wait state
        case (s_ff.addr)
            TMFD_TEX_W0_OFS: rd = s_ff.tw0;
            TMFD_TEX_W1_OFS: rd = s_ff.tw1;
            TMFD_TEX_W2_OFS: rd = s_ff.tw2;
            TMFD_MEM_W0_OFS: rd = s_ff.mw0;
            TMFD_CTRL_OFS:   rd[2:0] = s_ff.prog;
            TMFD_INDEX_OFS: begin
                rd[7:0]              = s_ff.loop_idx;
                rd[TMFD_I0_LSB +: 8] = s_ff.idx0;
                rd[TMFD_I1_LSB +: 8] = s_ff.idx1;
            end
            TMFD_IDXVAL_OFS: rd[15:0] = s_ff.idx_val;
            TMFD_STATUS_OFS: begin
                rd[TMFD_TERR_BIT]      = s_ff.tex_err;
                rd[TMFD_MERR_BIT]      = s_ff.mem_err;
                rd[TMFD_BUSY_BIT]      = (s_ff.bst == TMFD_RUN) | s_ff.mem_go;
                rd[TMFD_STEP_LSB +: 4] = s_ff.step;
            end
            TMFD_TEXDEC_OFS: begin
                rd[7:0]                = s_ff.res;
                rd[TMFD_DSAMP_LSB +: 5] = s_ff.samp;
                rd[TMFD_DSRC_LSB +: 7] = s_ff.src;
                rd[TMFD_DDST_LSB +: 7] = s_ff.dst;
            end
            TMFD_MEMDEC_OFS: begin
                rd[17:0]                 = s_ff.mscaled;
                rd[TMFD_DELEM_LSB +: 2]  = s_ff.esz;
                rd[TMFD_DBURST_LSB +: 4] = s_ff.last;
            end
            default: rd = 32'h00000000;
        endcase
        if (s_ff.rd_pend) begin
            nxt_s.rdata = rd;
        end

        // address phase capture
        if (take) begin
            nxt_s.addr    = {haddr[7:2], 2'b00};
            nxt_s.wr_pend = hwrite;
            nxt_s.rd_pend = ~hwrite;
        end

        // texture decode
        case (s_ff.tw0[TMFD_RIM_LSB +: 2])
            TMFD_IDX_0: radd = s_ff.idx0;
            TMFD_IDX_1: radd = s_ff.idx1;
            default:    radd = 8'h00;
        endcase
        case (s_ff.tw0[TMFD_SIM_LSB +: 2])
            TMFD_IDX_0: sadd = s_ff.idx0[4:0];
            TMFD_IDX_1: sadd = s_ff.idx1[4:0];
            default:    sadd = 5'h00;
        endcase
        if ((op < TMFD_OP_LD) || ((op >= TMFD_OP_RSV_HI) && (op < TMFD_OP_SAMPLE))) begin
            terr = 1'b1;
        end
        if ((op == TMFD_OP_LD) && (md > TMFD_MOD_FMASK)) begin
            terr = 1'b1;
        end
        if (((op == TMFD_OP_GRAD_H) || (op == TMFD_OP_GRAD_V)) && (md > TMFD_MOD_FINE)) begin
            terr = 1'b1;
        end
        if (s_ff.tw0[TMFD_RIM_LSB +: 2] == TMFD_IDX_BAD) begin
            terr = 1'b1;
        end
        if (s_ff.tw0[TMFD_SIM_LSB +: 2] == TMFD_IDX_BAD) begin
            terr = 1'b1;
        end
        if (s_ff.tw2[TMFD_SAMP_LSB +: 5] > TMFD_SAMP_MAX) begin
            terr = 1'b1;
        end
        for (int i = 0; i < 4; i++) begin
            if (s_ff.tw1[TMFD_DSEL_LSB + 3 * i +: 3] == TMFD_SEL_RSVD) begin
                terr = 1'b1;
            end
            if (s_ff.tw2[TMFD_SSEL_LSB + 3 * i +: 3] > TMFD_SEL_ONE) begin
                terr = 1'b1;
            end
        end

        nxt_s.tex_valid = s_ff.tex_go;
        if (s_ff.tex_go) begin
            nxt_s.op        = op;
            nxt_s.variant   = (op >= TMFD_OP_SAMPLE_G);
            nxt_s.grad_var  = (op == TMFD_OP_SAMPLE_G) || (op == TMFD_OP_SMP_G_LB) ||
                              (op == TMFD_OP_SMP_C_G) || (op == TMFD_OP_SC_G_LB);
            nxt_s.gather    = (op == TMFD_OP_GATHER4) || (op == TMFD_OP_GATHER4_O) ||
                              (op == TMFD_OP_GATHER4_C) || (op == TMFD_OP_G4_C_O);
            nxt_s.cmp       = (op >= TMFD_OP_SAMPLE_C);
            nxt_s.fmask     = (op == TMFD_OP_LD) && (md == TMFD_MOD_FMASK);
            nxt_s.fine      = ((op == TMFD_OP_GRAD_H) || (op == TMFD_OP_GRAD_V)) &&
                              (md == TMFD_MOD_FINE);
            nxt_s.gather_el = (op == TMFD_OP_GATHER4) ? md : 2'h0;
            nxt_s.full_quad = s_ff.tw0[TMFD_FWQ_BIT];
            nxt_s.res       = s_ff.tw0[TMFD_RES_LSB +: 8] + radd;
            nxt_s.samp      = s_ff.tw2[TMFD_SAMP_LSB +: 5] + sadd;
            nxt_s.src       = s_ff.tw0[TMFD_SRC_LSB +: 7] +
                              (s_ff.tw0[TMFD_SREL_BIT] ? s_ff.loop_idx[6:0] : 7'h00);
            nxt_s.alt       = s_ff.tw0[TMFD_ALT_BIT] && (s_ff.prog != TMFD_PROG_HULL) &&
                              (s_ff.prog != TMFD_PROG_LOCAL) &&
                              (s_ff.prog != TMFD_PROG_COMPUTE);
            nxt_s.dst       = s_ff.tw1[TMFD_DST_LSB +: 7] +
                              (s_ff.tw1[TMFD_DREL_BIT] ? s_ff.loop_idx[6:0] : 7'h00);
            nxt_s.dsel      = s_ff.tw1[TMFD_DSEL_LSB +: 12];
            nxt_s.lod       = s_ff.tw1[TMFD_LOD_LSB +: 7];
            nxt_s.cnorm     = s_ff.tw1[TMFD_CT_LSB +: 4];
            nxt_s.offs      = s_ff.tw2[TMFD_OFS_LSB +: 15];
            nxt_s.ssel      = s_ff.tw2[TMFD_SSEL_LSB +: 12];
            nxt_s.tex_err   = terr;
        end

        // memory-read decode
        if (s_ff.mw0[TMFD_OP_LSB +: 5] != TMFD_MEM_OPCODE) begin
            merr = 1'b1;
        end
        if (esz == TMFD_ESZ_BAD) begin
            merr = 1'b1;
        end
        if ((mop != TMFD_MOP_SCRATCH) && (mop != TMFD_MOP_SCATTER)) begin
            merr = 1'b1;
        end
        if (s_ff.mw0[TMFD_IDX_BIT]) begin
            case (esz)
                TMFD_ESZ_ONE: scaled = {2'b00, s_ff.idx_val};
                TMFD_ESZ_TWO: scaled = {1'b0, s_ff.idx_val, 1'b0};
                default:      scaled = {s_ff.idx_val, 2'b00};
            endcase
        end

        nxt_s.mvalid = 1'b0;
        case (s_ff.bst)
            TMFD_IDLE: begin
                if (s_ff.mem_go) begin
                    nxt_s.mem_go  = 1'b0;
                    nxt_s.mem_err = merr;
                    nxt_s.mop     = mop;
                    nxt_s.unc     = s_ff.mw0[TMFD_UNC_BIT];
                    nxt_s.msrc    = s_ff.mw0[TMFD_SRC_LSB +: 7] +
                                    (s_ff.mw0[TMFD_SREL_BIT] ? s_ff.loop_idx[6:0] : 7'h00);
                    nxt_s.mcomp   = s_ff.mw0[TMFD_MCOMP_LSB +: 2];
                    nxt_s.mscaled = scaled;
                    nxt_s.esz     = esz;
                    nxt_s.last    = s_ff.mw0[TMFD_BURST_LSB +: 4];
                    nxt_s.step    = 4'h0;
                    if (!merr) begin
                        nxt_s.mvalid = 1'b1;
                        nxt_s.bst    = TMFD_RUN;
                    end
                end
            end
            TMFD_RUN: begin
                if (s_ff.step == s_ff.last) begin
                    nxt_s.bst = TMFD_IDLE;
                end else begin
                    nxt_s.step   = s_ff.step + 4'h1;
                    nxt_s.mvalid = 1'b1;
                end
            end
            default: nxt_s.bst = TMFD_IDLE;
        endcase
        if (s_ff.wr_pend && (s_ff.addr == TMFD_MEM_W0_OFS)) begin
            nxt_s.mem_go = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // bus answers
    assign hreadyout = ~s_ff.rd_pend;
    assign hresp     = 1'b0;
    assign hrdata    = s_ff.rdata;

    // decoded outputs
    assign tex_valid                  = s_ff.tex_valid;
    assign texture_opcode             = s_ff.op;
    assign tex_variant                = s_ff.variant;
    assign tex_gradient_variant       = s_ff.grad_var;
    assign gather_four_op             = s_ff.gather;
    assign tex_compare_variant        = s_ff.cmp;
    assign direct_load_fmask          = s_ff.fmask;
    assign gradient_fine              = s_ff.fine;
    assign gather_element             = s_ff.gather_el;
    assign full_quad_fetch            = s_ff.full_quad;
    assign surface_select             = s_ff.res;
    assign filter_state_select        = s_ff.samp;
    assign source_reg_index           = s_ff.src;
    assign alternate_thread_constants = s_ff.alt;
    assign dest_reg_index             = s_ff.dst;
    assign dest_select                = s_ff.dsel;
    assign lod_bias                   = s_ff.lod;
    assign coordinate_normalization   = s_ff.cnorm;
    assign texel_offsets              = s_ff.offs;
    assign source_select              = s_ff.ssel;
    assign tex_error                  = s_ff.tex_err;
    assign mem_read_valid             = s_ff.mvalid;
    assign mem_burst_step             = s_ff.step;
    assign memory_sub_opcode          = s_ff.mop;
    assign mem_uncached               = s_ff.unc;
    assign mem_source_reg_index       = s_ff.msrc;
    assign mem_source_component       = s_ff.mcomp;
    assign mem_index_scaled           = s_ff.mscaled;
    assign mem_error                  = s_ff.mem_err;

endmodule : tmfd_decoder

// ---- verification/tmfd_decoder_asserts.sv ----
// port assertions for the fetch decoder
`timescale 1ns/1ns
module tmfd_decoder_asserts (
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // watched outputs
    input wire logic       hreadyout,
    input wire logic       tex_valid,
    input wire logic [4:0] texture_opcode,
    input wire logic       tex_variant,
    input wire logic       gather_four_op,
    input wire logic       direct_load_fmask,
    input wire logic       gradient_fine,
    input wire logic [1:0] gather_element,
    input wire logic       mem_read_valid,
    input wire logic [3:0] mem_burst_step,
    input wire logic       mem_error
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_first;
        $rose(mem_read_valid);
    endsequence
    sequence s_next;
        mem_read_valid && $past(mem_read_valid);
    endsequence
    property p_class;
        tex_variant == (texture_opcode >= 5'h14) &&
        gather_four_op == (texture_opcode inside {5'h15, 5'h17, 5'h1d, 5'h1f});
    endproperty
    property p_fmask;
        direct_load_fmask |-> texture_opcode == 5'h03;
    endproperty
    property p_fine;
        gradient_fine |-> texture_opcode inside {5'h07, 5'h08};
    endproperty
    property p_gath;
        gather_element != 2'h0 |-> texture_opcode == 5'h15;
    endproperty
    property p_pulse;
        tex_valid |=> !tex_valid;
    endproperty
    property p_ready;
        !hreadyout |=> hreadyout;
    endproperty
    property p_start;
        s_first |-> mem_burst_step == 4'h0 && !mem_error;
    endproperty
    property p_step;
        s_next |-> mem_burst_step == $past(mem_burst_step) + 4'h1;
    endproperty
    a_class: assert property (p_class) else $error("class flags wrong");
    a_fmask: assert property (p_fmask) else $error("fmask load wrong");
    a_fine: assert property (p_fine) else $error("fine gradient wrong");
    a_gath: assert property (p_gath) else $error("gather element wrong");
    a_pulse: assert property (p_pulse) else $error("issue pulse too long");
    a_ready: assert property (p_ready) else $error("wait state too long");
    a_start: assert property (p_start) else $error("burst start wrong");
    a_step: assert property (p_step) else $error("burst step wrong");
endmodule : tmfd_decoder_asserts
bind tmfd_decoder tmfd_decoder_asserts i_tmfd_decoder_asserts (.*);

// ---- verification/tmfd_sequencer.sv ----
// clause sequencer model issuing words over ahb-lite
`timescale 1ns/1ns
module tmfd_sequencer (
    // clock
    input wire logic        hclk,
    // ahb-lite master
    output logic            hsel,
    output logic [31:0]     haddr,
    output logic [1:0]      htrans,
    output logic            hwrite,
    output logic [2:0]      hsize,
    output logic [31:0]     hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task wait_rdy(inout int n);
        @(posedge hclk);
        while (!hready && n < 40) begin
            @(posedge hclk);
            n++;
        end
    endtask : wait_rdy
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy(n);
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy(n);
        q = hrdata;
        if (n >= 40) begin
            tmfd_decoder_tb.errors++;
            tmfd_decoder_tb.give_verdict();
        end
    endtask : xfer
endmodule : tmfd_sequencer

// ---- verification/tmfd_decoder_tb.sv ----
// self-checking bench for the fetch decoder
`timescale 1ns/1ns
module tmfd_decoder_tb
    import tmfd_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, tex_valid, tex_variant, gather_four_op;
    logic tex_compare_variant, direct_load_fmask, gradient_fine, full_quad_fetch, tex_error, hresp;
    logic tex_gradient_variant;
    logic alternate_thread_constants, mem_read_valid, mem_uncached, mem_error;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans, gather_element, mem_source_component;
    logic [2:0]  hsize, memory_sub_opcode;
    logic [4:0]  texture_opcode, filter_state_select;
    logic [6:0]  source_reg_index, dest_reg_index, lod_bias, mem_source_reg_index;
    logic [11:0] dest_select, source_select;
    logic [3:0]  coordinate_normalization, mem_burst_step;
    logic [7:0]  surface_select;
    logic [14:0] texel_offsets;
    logic [17:0] mem_index_scaled;
    int          errors, cmp_count;
    tmfd_decoder i_tmfd_decoder (.*, .hready(hreadyout));
    tmfd_sequencer i_tmfd_sequencer (.hclk, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata);
    always #4 hclk = ~hclk;
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task give_verdict;
        $display("compares %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        i_tmfd_sequencer.xfer(1'h1, a, d, r);
    endtask : wr
    task tex(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2);
        int n;
        n = 0;
        wr(TMFD_TEX_W0_OFS, w0);
        wr(TMFD_TEX_W1_OFS, w1);
        wr(TMFD_TEX_W3_OFS, 32'hffffffff);
        wr(TMFD_TEX_W2_OFS, w2);
        @(posedge hclk);
        while (!tex_valid && n < 20) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 20) begin
            errors++;
            give_verdict();
        end
    endtask : tex
    task scen_fields;
        tex(32'h13a01090, 32'haffd1091, 32'h68854321);
        chk(surface_select, 8'h13);
        chk(filter_state_select, 5'h11);
        chk(source_reg_index, 7'h25);
        chk(full_quad_fetch, 1'h1);
        chk(alternate_thread_constants, 1'h1);
        chk(dest_reg_index, 7'h16);
        chk(dest_select, 12'he88);
        chk(lod_bias, 7'h7f);
        chk(coordinate_normalization, 4'ha);
        chk(texel_offsets, 15'h4321);
        chk(source_select, 12'h688);
        chk(tex_error, 1'h0);
        i_tmfd_sequencer.xfer(1'h0, TMFD_TEXDEC_OFS, 32'h0, q);
        chk(q, 32'h16251113);
        i_tmfd_sequencer.xfer(1'h0, TMFD_TEX_W3_OFS, 32'h0, q);
        chk(q, 32'h0);
    endtask : scen_fields
    task scen_alt;
        wr(TMFD_CTRL_OFS, 32'h4);
        tex(32'h13a01090, 32'haffd1091, 32'h68894321);
        chk(alternate_thread_constants, 1'h0);
        chk(tex_error, 1'h1);
        chk(filter_state_select, 5'h19);
    endtask : scen_alt
    task scen_ops;
        logic [4:0] op;
        for (int m = 1; m < 3; m++) begin
            for (int i = 0; i < 32; i++) begin
                op = i[4:0];
                tex({25'h0, m[1:0], op}, 32'h0, 32'h0);
                chk(tex_variant, op >= 5'h14);
                chk(gather_four_op, op inside {5'h15, 5'h17, 5'h1d, 5'h1f});
                chk(tex_compare_variant, op >= 5'h18);
                chk(tex_gradient_variant, op inside {5'h14, 5'h16, 5'h1c, 5'h1e});
                chk(gather_element, op == 5'h15 ? m[1:0] : 2'h0);
                chk(direct_load_fmask, op == 5'h03 && m == 1);
                chk(gradient_fine, op inside {5'h07, 5'h08} && m == 1);
                chk(tex_error, op < 5'h03 || op inside {[5'h0d:5'h0f]} ||
                    (op inside {5'h03, 5'h07, 5'h08} && m > 1));
            end
        end
    endtask : scen_ops
    task scen_mem;
        logic [31:0] mw [5] = '{32'h0fa01a22, 32'h3c001062, 32'h502, 32'h3, 32'h42};
        int          np [5] = '{4, 16, 0, 0, 0};
        int          sc [5] = '{6, 12, 0, 0, 0};
        int          cnt;
        for (int i = 4; i >= 0; i--) begin
            wr(TMFD_MEM_W0_OFS, mw[i]);
            cnt = 0;
            repeat (24) begin
                @(posedge hclk);
                if (mem_read_valid === 1'h1) cnt++;
            end
            chk(cnt, np[i]);
            chk(mem_burst_step, np[i] > 0 ? np[i] - 1 : 0);
            chk(mem_error, np[i] == 0);
            if (np[i] > 0) chk(mem_index_scaled, sc[i]);
        end
        chk(mem_source_component, 2'h3);
        chk(memory_sub_opcode, 3'h2);
        chk(mem_uncached, 1'h1);
        chk(mem_source_reg_index, 7'h25);
    endtask : scen_mem
    initial begin
        hclk = 1'h0;
        hresetn = 1'h0;
        errors = 0;
        cmp_count = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'h1;
        @(posedge hclk);
        wr(TMFD_INDEX_OFS, 32'h00070305);
        wr(TMFD_CTRL_OFS, 32'h0);
        wr(TMFD_IDXVAL_OFS, 32'h3);
        scen_fields();
        scen_alt();
        scen_ops();
        scen_mem();
        i_tmfd_sequencer.xfer(1'h0, 8'h3c, 32'h0, q);
        chk(q, 32'h0);
        chk(hresp, 1'h0);
        give_verdict();
    end
endmodule : tmfd_decoder_tb
